// [clock_halt_pkg.sv]
// Constants, register map and state type for the clock, halt and reset control
`default_nettype none
package clock_halt_pkg;
    // Clock timing
    localparam int CORE_PERIOD_NS  = 100;
    localparam int OSC_PERIOD_NS   = 500;
    localparam int OSC_DIV         = OSC_PERIOD_NS / CORE_PERIOD_NS;
    localparam int STARTUP_US      = 1000;
    localparam int STARTUP_CYCLES  = STARTUP_US * 1000 / CORE_PERIOD_NS;
    localparam int TMR_W           = 14;
    localparam int OSC_CNT_W       = 3;
    localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST = 3'(OSC_DIV - 1);
    localparam logic [1:0] EXT_DIV_LAST = 2'h3;

    // Register byte offsets
    localparam logic [7:0] OFS_HALT   = 8'h00;
    localparam logic [7:0] OFS_CFG    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PMC    = 8'h0c;

    // Field positions
    localparam int HALT_REQ_BIT    = 0;
    localparam int CFG_SRC_LSB     = 0;
    localparam int ST_WAKE_FLAG    = 0;
    localparam int ST_OSC_RUN      = 1;
    localparam int ST_STARTING     = 2;
    localparam int ST_CORE_RUN     = 3;

    // Clock source select encodings
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_SQUARE   = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL  = 2'h2;
    localparam logic [1:0] SRC_RC       = 2'h3;
    localparam logic [1:0] SRC_RESET    = SRC_INTERNAL;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        PH_START,
        PH_RUN,
        PH_HALT,
        PH_WAKE
    } phase_t;
endpackage : clock_halt_pkg
`default_nettype wire

// [startup_timer.sv]
// Oscillator start-up delay counter
`timescale 1ns/1ps
`default_nettype none
module startup_timer #(
    parameter int CYCLES = clock_halt_pkg::STARTUP_CYCLES
) (
    input  wire logic CORE_CLK,
    input  wire logic RESET_N,
    input  wire logic load,
    output logic      done
);
    localparam logic [clock_halt_pkg::TMR_W-1:0] LOAD_VAL =
        clock_halt_pkg::TMR_W'(CYCLES - 1);

    logic [clock_halt_pkg::TMR_W-1:0] cnt_r;
    logic [clock_halt_pkg::TMR_W-1:0] cnt_nxt;

    assign done    = (cnt_r == '0);
    assign cnt_nxt = load ? LOAD_VAL : (done ? cnt_r : cnt_r - 1'b1);

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            cnt_r <= LOAD_VAL;
        else
            cnt_r <= cnt_nxt;
    end
endmodule : startup_timer
`default_nettype wire

// [clock_halt_reset_control.sv]
// Clock source selection, halt control and reset sequencing with AHB-Lite registers
//
// Notes on behaviour
// - Internal source: 2 MHz oscillator halved to 1 MHz instruction clock.
// - Two-bit source select: internal, square, crystal, RC.
// - Crystal, resonator or RC input divided by four.
// - Square clock input used undivided.
// - Oscillator runs unless halted or an external source selected.
// - Write one to bit 0 enters halt; bit write-only, self-clears.
// - Halt stops oscillator, low-battery and brown-out circuits.
// - Only a multi-input wakeup event or reset ends halt.
// - After wakeup, 1 ms start-up delay before execution resumes.
// - Reset puts all I/O in input mode; core and I/O released after start-up delay.
`timescale 1ns/1ps
`default_nettype none
module clock_halt_reset_control #(
    parameter int STARTUP_CYCLES = clock_halt_pkg::STARTUP_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        CLOCK_INPUT_PIN,
    input  wire logic        MULTI_INPUT_WAKEUP,
    output logic             CRYSTAL_OUTPUT_PIN,
    output logic             CRYSTAL_OUTPUT_OE,
    output logic             INSTR_CLK_EN,
    output logic             CORE_RESET_N,
    output logic             IO_RESET_N,
    output logic             CORE_RUN,
    output logic             OSC_ENABLE,
    output logic             LOW_BATTERY_DETECT_EN,
    output logic             BROWNOUT_RESET_EN
);
    clock_halt_pkg::phase_t phase_r;
    clock_halt_pkg::phase_t phase_nxt;

    logic [1:0]                         src_r;
    logic                               wake_flag_r;
    logic                               core_rst_n_r;
    logic [clock_halt_pkg::OSC_CNT_W-1:0] osc_cnt_r;
    logic                               osc_half_r;
    logic                               clk_in_q_r;
    logic [1:0]                         ext_div_r;
    logic                               instr_tick_r;
    logic                               wr_pend_r;
    logic [7:0]                         wr_addr_r;
    logic [31:0]                        hrdata_r;

    // Bus decode
    wire        addr_phase = HSEL & HREADY & (HTRANS == clock_halt_pkg::HTRANS_NONSEQ);
    wire        addr_hit   = (HADDR[31:8] == 24'h000000);
    wire [7:0]  addr_lo    = HADDR[7:0];
    wire        wr_halt    = wr_pend_r & (wr_addr_r == clock_halt_pkg::OFS_HALT);
    wire        wr_cfg     = wr_pend_r & (wr_addr_r == clock_halt_pkg::OFS_CFG);
    wire        wr_pmc     = wr_pend_r & (wr_addr_r == clock_halt_pkg::OFS_PMC);
    wire        halt_req   = wr_halt & HWDATA[clock_halt_pkg::HALT_REQ_BIT];

    // Clock generation
    wire halted      = (phase_r == clock_halt_pkg::PH_HALT);
    wire starting    = (phase_r == clock_halt_pkg::PH_START) |
                       (phase_r == clock_halt_pkg::PH_WAKE);
    wire src_int     = (src_r == clock_halt_pkg::SRC_INTERNAL);
    wire src_sq      = (src_r == clock_halt_pkg::SRC_SQUARE);
    wire osc_on      = src_int & ~halted;
    wire osc_tick    = osc_on & (osc_cnt_r == clock_halt_pkg::OSC_CNT_LAST);
    wire ext_rise    = CLOCK_INPUT_PIN & ~clk_in_q_r & ~src_int & ~halted;
    wire tick_int    = osc_tick & osc_half_r;
    wire tick_sq     = ext_rise & src_sq;
    wire tick_div4   = ext_rise & ~src_sq &
                       (ext_div_r == clock_halt_pkg::EXT_DIV_LAST);
    wire tick_nxt    = tick_int | tick_sq | tick_div4;

    wire timer_load;
    wire timer_done;

    assign timer_load = halted & MULTI_INPUT_WAKEUP;

    startup_timer #(
        .CYCLES (STARTUP_CYCLES)
    ) u_timer (
        .CORE_CLK (CORE_CLK),
        .RESET_N  (RESET_N),
        .load     (timer_load),
        .done     (timer_done)
    );

    // Phase sequencing
    always_comb
    begin
        phase_nxt = phase_r;
        case (phase_r)
            clock_halt_pkg::PH_START,
            clock_halt_pkg::PH_WAKE:
                if (timer_done & tick_nxt)
                    phase_nxt = clock_halt_pkg::PH_RUN;
            clock_halt_pkg::PH_RUN:
                if (halt_req)
                    phase_nxt = clock_halt_pkg::PH_HALT;
            clock_halt_pkg::PH_HALT:
                if (MULTI_INPUT_WAKEUP)
                    phase_nxt = clock_halt_pkg::PH_WAKE;
            default:
                phase_nxt = clock_halt_pkg::PH_START;
        endcase
    end

    wire wake_flag_nxt = (halted & MULTI_INPUT_WAKEUP) | (wake_flag_r & ~wr_pmc);

    // Read data
    wire [31:0] status_word = {28'h0000000,
                               phase_r == clock_halt_pkg::PH_RUN,
                               starting,
                               osc_on,
                               wake_flag_r};
    wire [31:0] cfg_word    = {30'h0, src_r};
    wire [31:0] rd_word     = !addr_hit ? 32'h00000000 :
                              (addr_lo == clock_halt_pkg::OFS_CFG)    ? cfg_word :
                              (addr_lo == clock_halt_pkg::OFS_STATUS) ? status_word :
                              32'h00000000;

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            phase_r      <= clock_halt_pkg::PH_START;
            src_r        <= clock_halt_pkg::SRC_RESET;
            wake_flag_r  <= 1'b0;
            core_rst_n_r <= 1'b0;
            instr_tick_r <= 1'b0;
        end
        else
        begin
            phase_r      <= phase_nxt;
            wake_flag_r  <= wake_flag_nxt;
            instr_tick_r <= tick_nxt;
            if (wr_cfg)
                src_r <= HWDATA[clock_halt_pkg::CFG_SRC_LSB +: 2];
            if (phase_r == clock_halt_pkg::PH_START && phase_nxt == clock_halt_pkg::PH_RUN)
                core_rst_n_r <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            osc_cnt_r  <= '0;
            osc_half_r <= 1'b0;
            clk_in_q_r <= 1'b0;
            ext_div_r  <= 2'h0;
        end
        else
        begin
            clk_in_q_r <= CLOCK_INPUT_PIN;
            osc_cnt_r  <= osc_tick | ~osc_on ? '0 : osc_cnt_r + 1'b1;
            osc_half_r <= osc_tick ? ~osc_half_r : osc_half_r;
            if (ext_rise & ~src_sq)
                ext_div_r <= ext_div_r + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h00000000;
        end
        else
        begin
            wr_pend_r <= addr_phase & HWRITE & addr_hit;
            wr_addr_r <= addr_lo;
            if (addr_phase & ~HWRITE)
                hrdata_r <= rd_word;
        end
    end

    assign HRDATA                = hrdata_r;
    assign HREADYOUT             = 1'b1;
    assign HRESP                 = 1'b0;
    assign INSTR_CLK_EN          = instr_tick_r;
    assign CORE_RESET_N          = core_rst_n_r;
    assign IO_RESET_N            = core_rst_n_r;
    assign CORE_RUN              = (phase_r == clock_halt_pkg::PH_RUN);
    assign OSC_ENABLE            = osc_on;
    assign LOW_BATTERY_DETECT_EN = ~halted;
    assign BROWNOUT_RESET_EN     = ~halted;
    assign CRYSTAL_OUTPUT_PIN    = ~clk_in_q_r;
    assign CRYSTAL_OUTPUT_OE     = (src_r == clock_halt_pkg::SRC_CRYSTAL) & ~halted;

    // Checks
    a_int_div_two: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (src_int && instr_tick_r && !halted) |=> !instr_tick_r [*8])
        else $error("internal instruction clock faster than 1 MHz");

    a_src_square: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (src_sq && !halted && CLOCK_INPUT_PIN && !clk_in_q_r) |=> instr_tick_r)
        else $error("square clock edge gave no instruction tick");

    a_div_four_gap: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (!src_int && !src_sq && instr_tick_r) |-> $past(ext_div_r) == clock_halt_pkg::EXT_DIV_LAST)
        else $error("divided clock tick off the fourth edge");

    a_osc_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (!src_int || halted) |-> !OSC_ENABLE ##1 (osc_cnt_r == '0))
        else $error("oscillator running while halted or external");

    a_halt_entry: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (CORE_RUN && wr_halt && HWDATA[clock_halt_pkg::HALT_REQ_BIT]) |=> halted)
        else $error("halt write did not enter halt");

    a_halt_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        halted |=> (!LOW_BATTERY_DETECT_EN && !BROWNOUT_RESET_EN && !INSTR_CLK_EN)
                   || !halted)
        else $error("systems alive during halt");

    a_halt_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (halted && !MULTI_INPUT_WAKEUP) |=> halted)
        else $error("halt left without wakeup");

    a_wake_delay: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (halted && MULTI_INPUT_WAKEUP) |=> (!CORE_RUN && !timer_done) [*8])
        else $error("execution resumed before start-up delay");

    a_run_synced: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        $rose(CORE_RESET_N) |-> INSTR_CLK_EN && $past(timer_done))
        else $error("reset released off an instruction clock edge");

    a_pmc_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (wr_pmc && !(halted && MULTI_INPUT_WAKEUP)) |=> !wake_flag_r)
        else $error("power mode clear write did not clear flag");
endmodule : clock_halt_reset_control
`default_nettype wire

// [clock_halt_reset_control_tb.sv]
// Self-checking testbench for the clock, halt and reset control
`timescale 1ns/1ps
`default_nettype none
module clock_halt_reset_control_tb;
    localparam int ST = 20;
    logic        CORE_CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic        PIN = 1'b0;
    logic        WAKE = 1'b0;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, XO, XO_OE, TICK, CRST_N, IORST_N, RUN, OSC, LOW_BATTERY_DETECT, BOR;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          ticks = 0;
    int          cyc = 0;
    int          last_tick = 0;
    int          last_gap = 0;

    clock_halt_reset_control #(.STARTUP_CYCLES(ST)) DUT (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLOCK_INPUT_PIN(PIN),
        .MULTI_INPUT_WAKEUP(WAKE), .CRYSTAL_OUTPUT_PIN(XO), .CRYSTAL_OUTPUT_OE(XO_OE),
        .INSTR_CLK_EN(TICK), .CORE_RESET_N(CRST_N), .IO_RESET_N(IORST_N), .CORE_RUN(RUN),
        .OSC_ENABLE(OSC), .LOW_BATTERY_DETECT_EN(LOW_BATTERY_DETECT), .BROWNOUT_RESET_EN(BOR));

    always #50 CORE_CLK = ~CORE_CLK;

    // Tick count and spacing between instruction ticks
    always @(posedge CORE_CLK)
    begin
        cyc <= cyc + 1;
        if (TICK === 1'b1)
        begin
            ticks <= ticks + 1;
            last_gap <= cyc - last_tick;
            last_tick <= cyc;
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge CORE_CLK);
        HSEL <= 1'b1;
        HADDR <= {24'h000000, a};
        HWRITE <= wr;
        HTRANS <= clock_halt_pkg::HTRANS_NONSEQ;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask : bus

    task automatic t_reset();
        int n;
        repeat (20) @(posedge CORE_CLK);
        chk_bit(CRST_N, 1'b0);
        chk_bit(IORST_N, 1'b0);
        chk_bit(OSC, 1'b1);
        RESET_N <= 1'b1;
        n = 0;
        while (CRST_N !== 1'b1 && n < ST + 40)
        begin
            @(negedge CORE_CLK);
            n++;
        end
        chk_bit(TICK, 1'b1);
        chk_bit(n >= ST, 1'b1);
        chk_bit(IORST_N, 1'b1);
        repeat (30) @(negedge CORE_CLK);
        chk_val(32'(last_gap), 32'h0000000a);
        chk_bit(HRESP, 1'b0);
    endtask : t_reset

    task automatic t_src();
        logic [31:0] rd;
        int          t0;
        bus(1'b1, 8'h40, 32'hffffffff, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk_val(rd, 32'h0);
        for (int s = 1; s < 4; s++)
        begin
            bus(1'b1, clock_halt_pkg::OFS_CFG, 32'(s), rd);
            bus(1'b0, clock_halt_pkg::OFS_CFG, 32'h0, rd);
            chk_val(rd, 32'(s));
            repeat (3) @(posedge CORE_CLK);
            t0 = ticks;
            repeat (8)
            begin
                PIN <= 1'b1;
                @(posedge CORE_CLK);
                PIN <= 1'b0;
                repeat (2) @(posedge CORE_CLK);
            end
            repeat (3) @(negedge CORE_CLK);
            chk_val(32'(ticks - t0), (s == 1) ? 32'h8 : 32'h2);
            chk_bit(OSC, 1'b0);
            chk_bit(XO_OE, s == 2);
            chk_bit(XO, 1'b1);
        end
        bus(1'b1, clock_halt_pkg::OFS_CFG, 32'h0, rd);
        repeat (30) @(negedge CORE_CLK);
        chk_val(32'(last_gap), 32'h0000000a);
        chk_bit(OSC, 1'b1);
    endtask : t_src

    task automatic t_halt();
        logic [31:0] rd;
        int          t0;
        int          n;
        bus(1'b1, clock_halt_pkg::OFS_HALT, 32'h2, rd);
        repeat (3) @(negedge CORE_CLK);
        chk_bit(RUN, 1'b1);
        bus(1'b1, clock_halt_pkg::OFS_HALT, 32'h1, rd);
        repeat (3) @(negedge CORE_CLK);
        chk_bit(RUN, 1'b0);
        chk_val({29'h0, OSC, LOW_BATTERY_DETECT, BOR}, 32'h0);
        t0 = ticks;
        bus(1'b0, clock_halt_pkg::OFS_HALT, 32'h0, rd);
        chk_val(rd, 32'h0);
        repeat (50) @(negedge CORE_CLK);
        chk_val(32'(ticks - t0), 32'h0);
        chk_bit(RUN, 1'b0);
        @(posedge CORE_CLK);
        WAKE <= 1'b1;
        @(posedge CORE_CLK);
        WAKE <= 1'b0;
        n = 0;
        while (RUN !== 1'b1 && n < ST + 40)
        begin
            @(negedge CORE_CLK);
            n++;
        end
        chk_bit(n >= ST - 2 && n <= ST + 12, 1'b1);
        chk_val({29'h0, OSC, LOW_BATTERY_DETECT, BOR}, 32'h7);
        bus(1'b0, clock_halt_pkg::OFS_STATUS, 32'h0, rd);
        chk_val(rd & 32'hf, 32'hb);
        bus(1'b1, clock_halt_pkg::OFS_PMC, 32'h0, rd);
        bus(1'b0, clock_halt_pkg::OFS_STATUS, 32'h0, rd);
        chk_val(rd & 32'h1, 32'h0);
        repeat (5) @(negedge CORE_CLK);
        chk_bit(RUN, 1'b1);
    endtask : t_halt

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        t_reset();
        t_src();
        t_halt();
        final_report();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #(100 * 5000);
        n_mismatch++;
        final_report();
    end
endmodule : clock_halt_reset_control_tb
`default_nettype wire
